// File: common/split_timer_pkg.sv
package split_timer_pkg;

  // register map, byte addresses on the slave port
  localparam int unsigned ADDR_W       = 6;
  localparam int unsigned DATA_W       = 32;
  localparam logic [5:0]  OFF_CONTROL  = 6'h00;
  localparam logic [5:0]  OFF_CNT_LO   = 6'h04;
  localparam logic [5:0]  OFF_CNT_HI   = 6'h08;
  localparam logic [5:0]  OFF_RLD_LO   = 6'h0c;
  localparam logic [5:0]  OFF_RLD_HI   = 6'h10;
  localparam logic [5:0]  OFF_CLK_SEL  = 6'h14;
  localparam logic [5:0]  OFF_IRQ_EN   = 6'h18;
  localparam logic [5:0]  OFF_STATUS   = 6'h1c;
  localparam logic [5:0]  OFF_MASK     = 6'h20;

  // field positions
  localparam int unsigned CKSEL_LOW_BIT  = 0;
  localparam int unsigned CKSEL_HIGH_BIT = 1;
  localparam int unsigned IEN_TIMER_BIT  = 0;
  localparam int unsigned ST_HIGH_BIT    = 0;
  localparam int unsigned ST_LOW_BIT     = 1;
  localparam int unsigned ST_CAP_BIT     = 2;

  // reset values
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [1:0]  CLK_SEL_RESET = 2'h0;
  localparam logic        IRQ_EN_RESET  = 1'b0;
  localparam logic [2:0]  STATUS_RESET  = 3'h0;
  localparam logic [2:0]  MASK_RESET    = 3'h7;

  // count limits
  localparam logic [7:0]  BYTE_TOP      = 8'hff;
  localparam logic [7:0]  BYTE_ONE      = 8'h01;
  localparam logic [3:0]  DIV12_LAST    = 4'hb;
  localparam logic [2:0]  DIV8_LAST     = 3'h7;

  // timer control register layout, msb first
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic capture_enable;
    logic split_mode;
    logic run_control;
    logic capture_source_select;
    logic external_clock_select;
  } timer_control_s;

  // synchronised external inputs
  typedef struct packed {
    logic slow_osc;
    logic sof;
    logic ext;
  } async_in_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;

endpackage

// File: logic/split_timer.sv
`timescale 1ns/10ps

// Notes on behaviour
// - count is two byte registers, low and high, forming one 16-bit value.
// - tick sources are system clock, clock/12 and synchronised external/8.
// - 16-bit mode rolls 0xFFFF to reload value and sets high overflow flag.
// - 16-bit mode requests interrupt on every overflow when timer irq enabled.
// - 16-bit mode with low irq enable also interrupts on low byte wrap.
// - split mode runs two 8-bit auto-reload timers from their own reloads.
// - split mode run bit gates high byte only; low byte always counts.
// - per-half clock select picks system clock, else /12 or external /8.
// - split mode sets high and low flags on each byte wrap.
// - split mode interrupts on high wrap, and low wrap when enabled.
// - overflow flags never clear by hardware; software writes zero.
// - mode comes from split and capture enable bits.
// - capture enable selects capture mode; source bit picks event.
// - source 0 is start-of-frame, 1 is slow oscillator falling edge.
// - capture mode without split counts 16 bits wrapping to zero.
// - capture copies count bytes into reload bytes and requests interrupt.
// - capture mode with split wraps each byte and captures both bytes.
module split_timer
  import split_timer_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [DATA_W-1:0]   avs_readdata,
  output logic                     avs_waitrequest,
  // event sources
  input  wire logic                ext_clock,
  input  wire logic                usb_sof,
  input  wire logic                low_freq_oscillator,
  // interrupt
  output logic                     irq
);

  function automatic logic tick_pick(input logic sys_sel, input logic ext_sel,
                                     input logic t12, input logic t8);
    if (sys_sel)
      return 1'b1;
    else if (ext_sel)
      return t8;
    else
      return t12;
  endfunction

  function automatic logic [7:0] byte_next(input logic wrap, input logic reload_en,
                                           input logic [7:0] cur, input logic [7:0] rld);
    if (!wrap)
      return cur + BYTE_ONE;
    else if (reload_en)
      return rld;
    else
      return BYTE_RESET;
  endfunction

  timer_control_s   ctrl_q;
  logic [7:0]       count_low_byte_q;
  logic [7:0]       count_high_byte_q;
  logic [7:0]       reload_low_byte_q;
  logic [7:0]       reload_high_byte_q;
  logic [1:0]       clock_select_q;
  logic             timer_irq_enable_q;
  logic [2:0]       status_q;
  logic [2:0]       mask_q;
  bus_state_e       state_q;
  logic             wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic             irq_q;
  async_in_s        sync1_q;
  async_in_s        sync2_q;
  async_in_s        sync3_q;
  logic [3:0]       div12_q;
  logic [2:0]       div8_q;

  logic             tick12;
  logic             tick8;
  logic             ext_rise;
  logic             sof_pulse;
  logic             osc_fall;
  logic             capture_ev;
  logic             low_tick;
  logic             high_tick;
  logic             low_wrap;
  logic             high_wrap;
  logic             step_low;
  logic             step_high;
  logic             reload_en;
  logic [7:0]       count_low_d;
  logic [7:0]       count_high_d;
  logic             wr_ok;
  logic             rd_ok;
  logic [2:0]       events;
  logic [7:0]       wbyte;

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq             = irq_q;

  // input synchronisers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end
    else
    begin
      sync1_q <= '{slow_osc: low_freq_oscillator, sof: usb_sof, ext: ext_clock};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // edge detectors on the synchronised levels
  assign ext_rise  = sync2_q.ext & ~sync3_q.ext;
  assign sof_pulse = sync2_q.sof & ~sync3_q.sof;
  assign osc_fall  = ~sync2_q.slow_osc & sync3_q.slow_osc;

  // source select: 0 start-of-frame, 1 slow oscillator edge
  assign capture_ev = ctrl_q.capture_enable &
                      (ctrl_q.capture_source_select ? osc_fall : sof_pulse);

  // system clock / 12 enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div12_q <= 4'h0;
    else if (div12_q == DIV12_LAST)
      div12_q <= 4'h0;
    else
      div12_q <= div12_q + 4'h1;
  end

  assign tick12 = (div12_q == DIV12_LAST);

  // external clock / 8, counted on synchronised rising edges
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div8_q <= 3'h0;
    else if (ext_rise)
      div8_q <= div8_q + 3'h1;
  end

  assign tick8 = ext_rise & (div8_q == DIV8_LAST);

  assign low_tick  = tick_pick(clock_select_q[CKSEL_LOW_BIT], ctrl_q.external_clock_select,
                               tick12, tick8);
  assign high_tick = tick_pick(clock_select_q[CKSEL_HIGH_BIT], ctrl_q.external_clock_select,
                               tick12, tick8);

  // counting and wrap detection
  always_comb
  begin
    reload_en = ~ctrl_q.capture_enable;
    if (ctrl_q.split_mode)
    begin
      step_low  = low_tick;
      step_high = ctrl_q.run_control & high_tick;
      low_wrap  = step_low & (count_low_byte_q == BYTE_TOP);
      high_wrap = step_high & (count_high_byte_q == BYTE_TOP);
      count_low_d  = byte_next(low_wrap, reload_en, count_low_byte_q,
                               reload_low_byte_q);
      count_high_d = byte_next(high_wrap, reload_en, count_high_byte_q,
                               reload_high_byte_q);
    end
    else
    begin
      step_low  = ctrl_q.run_control & low_tick;
      step_high = step_low & (count_low_byte_q == BYTE_TOP);
      low_wrap  = step_high;
      high_wrap = step_high & (count_high_byte_q == BYTE_TOP);
      if (high_wrap)
      begin
        count_low_d  = reload_en ? reload_low_byte_q : BYTE_RESET;
        count_high_d = reload_en ? reload_high_byte_q : BYTE_RESET;
      end
      else
      begin
        count_low_d  = step_low ? count_low_byte_q + BYTE_ONE : count_low_byte_q;
        count_high_d = step_high ? count_high_byte_q + BYTE_ONE : count_high_byte_q;
      end
    end
    if (!step_low)
      count_low_d = count_low_byte_q;
    if (!step_high)
      count_high_d = count_high_byte_q;
  end

  // bus handshake
  assign wr_ok = (state_q == BUS_ACK) & avs_write & avs_byteenable[0];
  assign rd_ok = (state_q == BUS_ACK) & avs_read;
  assign wbyte = avs_writedata[7:0];

  function automatic logic wr_hit(input logic en, input logic [ADDR_W-1:0] addr,
                                  input logic [5:0] off);
    return en & ({addr[ADDR_W-1:2], 2'b00} == off);
  endfunction

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= BUS_IDLE;
      wait_q  <= 1'b1;
    end
    else
    begin
      case (state_q)
        BUS_IDLE:
        begin
          if (avs_read | avs_write)
          begin
            state_q <= BUS_ACK;
            wait_q  <= 1'b0;
          end
        end
        BUS_ACK:
        begin
          state_q <= BUS_IDLE;
          wait_q  <= 1'b1;
        end
        default:
        begin
          state_q <= BUS_IDLE;
          wait_q  <= 1'b1;
        end
      endcase
    end
  end

  // read data captured as the answer is raised
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_q <= '0;
    else if (state_q == BUS_IDLE && avs_read)
    begin
      rdata_q <= '0;
      case ({avs_address[ADDR_W-1:2], 2'b00})
        OFF_CONTROL: rdata_q[7:0] <= ctrl_q;
        OFF_CNT_LO:  rdata_q[7:0] <= count_low_byte_q;
        OFF_CNT_HI:  rdata_q[7:0] <= count_high_byte_q;
        OFF_RLD_LO:  rdata_q[7:0] <= reload_low_byte_q;
        OFF_RLD_HI:  rdata_q[7:0] <= reload_high_byte_q;
        OFF_CLK_SEL: rdata_q[1:0] <= clock_select_q;
        OFF_IRQ_EN:  rdata_q[0]   <= timer_irq_enable_q;
        OFF_STATUS:  rdata_q[2:0] <= status_q;
        OFF_MASK:    rdata_q[2:0] <= mask_q;
        default:     rdata_q      <= '0;
      endcase
    end
  end

  // control register; hardware set wins over software clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl_q <= CONTROL_RESET;
    else
    begin
      if (wr_hit(wr_ok, avs_address, OFF_CONTROL))
        ctrl_q <= wbyte;
      if (high_wrap)
        ctrl_q.high_overflow_flag <= 1'b1;
      if (low_wrap)
        ctrl_q.low_overflow_flag <= 1'b1;
    end
  end

  // count bytes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_low_byte_q  <= BYTE_RESET;
      count_high_byte_q <= BYTE_RESET;
    end
    else
    begin
      count_low_byte_q  <= count_low_d;
      count_high_byte_q <= count_high_d;
      if (wr_hit(wr_ok, avs_address, OFF_CNT_LO))
        count_low_byte_q <= wbyte;
      if (wr_hit(wr_ok, avs_address, OFF_CNT_HI))
        count_high_byte_q <= wbyte;
    end
  end

  // reload bytes, overwritten by a capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reload_low_byte_q  <= BYTE_RESET;
      reload_high_byte_q <= BYTE_RESET;
    end
    else if (capture_ev)
    begin
      reload_low_byte_q  <= count_low_byte_q;
      reload_high_byte_q <= count_high_byte_q;
    end
    else
    begin
      if (wr_hit(wr_ok, avs_address, OFF_RLD_LO))
        reload_low_byte_q <= wbyte;
      if (wr_hit(wr_ok, avs_address, OFF_RLD_HI))
        reload_high_byte_q <= wbyte;
    end
  end

  // clock select and interrupt enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clock_select_q     <= CLK_SEL_RESET;
      timer_irq_enable_q <= IRQ_EN_RESET;
      mask_q             <= MASK_RESET;
    end
    else
    begin
      if (wr_hit(wr_ok, avs_address, OFF_CLK_SEL))
        clock_select_q <= wbyte[1:0];
      if (wr_hit(wr_ok, avs_address, OFF_IRQ_EN))
        timer_irq_enable_q <= wbyte[IEN_TIMER_BIT];
      if (wr_hit(wr_ok, avs_address, OFF_MASK))
        mask_q <= wbyte[2:0];
    end
  end

  // interrupt events
  always_comb
  begin
    events = '0;
    events[ST_HIGH_BIT] = timer_irq_enable_q & high_wrap;
    events[ST_LOW_BIT]  = timer_irq_enable_q & ctrl_q.low_byte_irq_enable & low_wrap;
    events[ST_CAP_BIT]  = timer_irq_enable_q & capture_ev;
  end

  // sticky status; a read clears only the bits it returned
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status_q <= STATUS_RESET;
    else if (wr_hit(rd_ok, avs_address, OFF_STATUS))
      status_q <= (status_q & ~rdata_q[2:0]) | events;
    else
      status_q <= status_q | events;
  end

  // interrupt level from unmasked sticky status
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= |(status_q & mask_q);
  end

endmodule

// File: test/split_timer_monitor.sv
`timescale 1ns/10ps
module split_timer_monitor
  import split_timer_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  // events and interrupt
  input wire logic              ext_clock,
  input wire logic              usb_sof,
  input wire logic              low_freq_oscillator,
  input wire logic              irq
);
  logic       rd_done, wr_done, at_ctrl, at_stat, ien_q, quiet_q, mzero_q;
  logic [5:0] ctrl_q;
  logic [1:0] flag_q;
  assign rd_done = avs_read && !avs_waitrequest;
  assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign at_ctrl = avs_address[5:2] == OFF_CONTROL[5:2];
  assign at_stat = avs_address[5:2] == OFF_STATUS[5:2];
  // shadow of software writes and of flags already seen set
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      {ctrl_q, flag_q, ien_q, quiet_q, mzero_q} <= '0;
    end
    else
    begin
      if (wr_done && at_ctrl)
        {ctrl_q, flag_q} <= {avs_writedata[5:0], 2'h0};
      else if (rd_done && at_ctrl)
        flag_q <= flag_q | avs_readdata[7:6];
      if (wr_done && avs_address[5:2] == OFF_IRQ_EN[5:2])
        ien_q <= avs_writedata[0];
      if (wr_done && avs_address[5:2] == OFF_MASK[5:2])
        mzero_q <= avs_writedata[2:0] == 3'h0;
      if (wr_done && avs_address[5:2] == OFF_IRQ_EN[5:2] && avs_writedata[0])
        quiet_q <= 1'b0;
      else if (rd_done && at_stat && !ien_q)
        quiet_q <= 1'b1;
    end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_wait_one;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer not after one wait cycle");
  property p_wait_idle;
    !(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low while idle");
  property p_rd_upper;
    rd_done |-> avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data above byte not zero");
  property p_ctrl_bits;
    rd_done && at_ctrl |-> avs_readdata[5:0] == ctrl_q;
  endproperty
  a_ctrl_bits: assert property (p_ctrl_bits) else $error("control bits differ from written");
  property p_high_sticky;
    rd_done && at_ctrl && flag_q[1] |-> avs_readdata[7];
  endproperty
  a_high_sticky: assert property (p_high_sticky) else $error("high flag cleared itself");
  property p_low_sticky;
    rd_done && at_ctrl && flag_q[0] |-> avs_readdata[6];
  endproperty
  a_low_sticky: assert property (p_low_sticky) else $error("low flag cleared itself");
  property p_no_irq_off;
    quiet_q && $past(quiet_q) |-> !irq;
  endproperty
  a_no_irq_off: assert property (p_no_irq_off) else $error("irq with timer irq disabled");
  property p_no_irq_masked;
    mzero_q && $past(mzero_q) |-> !irq;
  endproperty
  a_no_irq_masked: assert property (p_no_irq_masked) else $error("irq with all sources masked");
  c_flag_seen: cover property (rd_done && at_ctrl && avs_readdata[7]);
  c_irq_rose: cover property ($rose(irq));
  c_capture: cover property (rd_done && at_stat && avs_readdata[2]);
endmodule

bind split_timer split_timer_monitor mon (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ext_clock(ext_clock), .usb_sof(usb_sof), .low_freq_oscillator(low_freq_oscillator), .irq(irq));

// File: test/split_timer_tb.sv
`timescale 1ns/10ps
module split_timer_tb
  import split_timer_pkg::*;
;
  logic        clk, rst, rd, wr, wreq, ext, eph, ext_run, sof, slow_osc, irq;
  logic [5:0]  addr;
  logic [31:0] wd;
  logic [31:0] rdata;
  logic [3:0]  be;
  logic [7:0]  r1, r2;
  logic [17:0] e;
  logic [17:0] expq[$];
  int          n_mismatch, checks_done;

  split_timer uut (.clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .ext_clock(ext), .usb_sof(sof), .low_freq_oscillator(slow_osc), .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // external oscillator, rising edge every four clocks
  always @(posedge clk)
    if (ext_run)
      {ext, eph} <= {ext ^ eph, ~eph};

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp_data(input logic [7:0] g, input logic [7:0] w);
    checks_done++;
    n_mismatch += int'(g !== w);
    if (g !== w)
      $display("MISMATCH t=%0t data got %h exp %h", $time, g, w);
  endtask
  task automatic cmp_irq(input logic g, input logic w);
    checks_done++;
    n_mismatch += int'(g !== w);
    if (g !== w)
      $display("MISMATCH t=%0t irq got %h exp %h", $time, g, w);
  endtask
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d, input logic [3:0] b);
    int n;
    n = 0;
    {addr, wd, be, rd, wr} <= {a, 24'h00_0000, d, b, ~w, w};
    @(posedge clk);
    while (wreq !== 1'b0 && n < 100)
    begin
      n++;
      @(posedge clk);
    end
    {rd, wr} <= 2'h0;
    if (n == 100)
    begin
      n_mismatch++;
      wrap_up();
    end
    @(posedge clk);
  endtask
  task automatic wrr(input logic [5:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 4'hf);
  endtask
  // expected data, care mask, irq check enable and irq value
  task automatic chk(input logic [5:0] a, input logic [7:0] d, input logic [7:0] m, input logic [1:0] i);
    expq.push_back({d, m, i});
    bus(a, 1'b0, 8'h00, 4'hf);
  endtask
  task automatic arm(input logic [7:0] h, input logic [7:0] l, input logic [7:0] c, input int n);
    wrr(OFF_CONTROL, 8'h00);
    wrr(OFF_CNT_HI, h);
    wrr(OFF_CNT_LO, l);
    wrr(OFF_CONTROL, c);
    repeat (n) @(posedge clk);
  endtask

  always @(posedge clk)
    if (rd === 1'b1 && wreq === 1'b0)
    begin
      e = expq.pop_front();
      cmp_data(rdata[7:0] & e[9:2], e[17:10] & e[9:2]);
      if (e[1])
        cmp_irq(irq, e[0]);
    end

  initial
  begin
    {rst, rd, wr, sof, ext, eph, ext_run, slow_osc} = 8'h81;
    {addr, wd, be} = '0;
    {n_mismatch, checks_done} = '0;
    void'($urandom(32'h4e7b));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++)
      chk(6'(i * 4), (i == 8) ? 8'h07 : 8'h00, 8'hff, 2'b10);
    $display("test reset values done");
    r1 = 8'($urandom | 1);
    r2 = 8'($urandom);
    wrr(OFF_RLD_LO, r1);
    wrr(OFF_RLD_HI, r2);
    bus(OFF_RLD_LO, 1'b1, ~r1, 4'h0);
    chk(OFF_RLD_LO, r1, 8'hff, 2'b00);
    chk(OFF_RLD_HI, r2, 8'hff, 2'b00);
    $display("test reload access done");
    wrr(OFF_CLK_SEL, 8'h03);
    wrr(OFF_RLD_HI, 8'hab);
    wrr(OFF_RLD_LO, 8'h12);
    arm(8'hff, 8'hfe, 8'h04, 10);
    chk(OFF_CONTROL, 8'h84, 8'hbf, 2'b10);
    chk(OFF_CNT_HI, 8'hab, 8'hff, 2'b10);
    chk(OFF_STATUS, 8'h00, 8'h07, 2'b10);
    chk(OFF_CONTROL, 8'h84, 8'hbf, 2'b10);
    wrr(OFF_IRQ_EN, 8'h01);
    arm(8'hff, 8'hfe, 8'h04, 10);
    chk(OFF_CONTROL, 8'h84, 8'hbf, 2'b11);
    wrr(OFF_MASK, 8'h00);
    chk(OFF_CNT_HI, 8'hab, 8'hff, 2'b10);
    wrr(OFF_MASK, 8'h07);
    chk(OFF_STATUS, 8'h01, 8'h07, 2'b11);
    chk(OFF_STATUS, 8'h00, 8'h07, 2'b10);
    $display("test 16-bit reload done");
    arm(8'h00, 8'hfe, 8'h24, 10);
    chk(OFF_STATUS, 8'h02, 8'h07, 2'b11);
    chk(OFF_CONTROL, 8'h64, 8'hff, 2'b10);
    chk(OFF_CNT_HI, 8'h01, 8'hff, 2'b10);
    $display("test low byte interrupt done");
    wrr(OFF_CLK_SEL, 8'h01);
    wrr(OFF_RLD_LO, 8'h40);
    wrr(OFF_RLD_HI, 8'h50);
    arm(8'hfe, 8'hfe, 8'h08, 10);
    chk(OFF_CONTROL, 8'h48, 8'hff, 2'b10);
    chk(OFF_CNT_HI, 8'hfe, 8'hff, 2'b10);
    chk(OFF_CNT_LO, 8'h40, 8'hc0, 2'b10);
    wrr(OFF_CONTROL, 8'h0c);
    repeat (40) @(posedge clk);
    chk(OFF_CONTROL, 8'h8c, 8'hff, 2'b11);
    chk(OFF_CNT_HI, 8'h50, 8'hf0, 2'b11);
    chk(OFF_STATUS, 8'h01, 8'h07, 2'b11);
    $display("test split mode done");
    wrr(OFF_CLK_SEL, 8'h00);
    arm(8'h00, 8'h00, 8'h04, 120);
    chk(OFF_CNT_LO, 8'h08, 8'hf8, 2'b00);
    ext_run <= 1'b1;
    arm(8'h00, 8'h00, 8'h05, 300);
    chk(OFF_CNT_LO, 8'h08, 8'hf8, 2'b00);
    $display("test tick sources done");
    arm(r1, r2, 8'h10, 0);
    sof <= 1'b1;
    repeat (3) @(posedge clk);
    sof <= 1'b0;
    repeat (8) @(posedge clk);
    chk(OFF_RLD_LO, r2, 8'hff, 2'b11);
    chk(OFF_RLD_HI, r1, 8'hff, 2'b11);
    chk(OFF_STATUS, 8'h04, 8'h07, 2'b11);
    arm(r1, ~r2, 8'h12, 0);
    sof <= 1'b1;
    repeat (3) @(posedge clk);
    sof <= 1'b0;
    repeat (8) @(posedge clk);
    chk(OFF_RLD_LO, r2, 8'hff, 2'b10);
    slow_osc <= 1'b0;
    repeat (8) @(posedge clk);
    chk(OFF_RLD_LO, ~r2, 8'hff, 2'b11);
    wrr(OFF_CLK_SEL, 8'h03);
    arm(8'hff, 8'hfe, 8'h16, 10);
    chk(OFF_CNT_HI, 8'h00, 8'hff, 2'b00);
    arm(r2, 8'h00, 8'h1a, 0);
    slow_osc <= 1'b1;
    repeat (3) @(posedge clk);
    slow_osc <= 1'b0;
    repeat (8) @(posedge clk);
    chk(OFF_RLD_HI, r2, 8'hff, 2'b00);
    chk(OFF_RLD_LO, 8'h00, 8'hf8, 2'b00);
    $display("test capture done");
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule
